// File: src/flag_xfer_consts.vh
// Constants for the flag and data-transfer execution unit
//
// Behaviour
// - Overflow raise sets V to one, overflow clear sets V to zero, others kept.
// - Transfer-bit raise writes one into T, transfer-bit clear writes zero.
// - Half-carry raise writes one into H, half-carry clear writes zero.
// - Each single-flag instruction takes one cycle and touches only its flag.
// - Register copy puts source into destination, source unchanged.
// - Pair copy moves both bytes together: source+1 to dest+1, source to dest.
// - Constant load writes the instruction's 8-bit constant into the destination.
// - Copy, pair copy and constant load keep flags and take one cycle.
// - Plain read through X loads destination from memory at X, X unchanged.
// - Post-increment read loads from the old pointer, then adds one.
// - Post-increment reads also through Y and Z, same order.
// - Pre-decrement read through X subtracts one first, then reads there.
// - Pre-decrement reads also through Y and Z, decrement first.
// - Displacement read uses Y or Z plus offset, pointer unchanged.
// - Direct read loads destination from the address in the instruction.
// - Plain write through X stores source at X, X unchanged.
// - Pre-decrement write through X subtracts one first, then stores.
// - Pre-decrement write through Y subtracts one first, then stores.
`ifndef FLAG_XFER_CONSTS_VH
`define FLAG_XFER_CONSTS_VH

`define OP_NOP 5'h00
`define OP_RAISE_OVERFLOW 5'h01
`define OP_CLEAR_OVERFLOW 5'h02
`define OP_RAISE_TRANSFER 5'h03
`define OP_CLEAR_TRANSFER 5'h04
`define OP_RAISE_HALF 5'h05
`define OP_CLEAR_HALF 5'h06
`define OP_COPY_REGISTER 5'h07
`define OP_COPY_PAIR 5'h08
`define OP_LOAD_CONSTANT 5'h09
`define OP_READ_POINTER 5'h0A
`define OP_READ_OFFSET 5'h0B
`define OP_READ_DIRECT 5'h0C
`define OP_WRITE_POINTER 5'h0D
`define OP_WRITE_OFFSET 5'h0E
`define OP_WRITE_DIRECT 5'h0F

`define MODE_PLAIN 2'h0
`define MODE_POST_INC 2'h1
`define MODE_PRE_DEC 2'h2

`define PTR_X 2'h0
`define PTR_Y 2'h1
`define PTR_Z 2'h2

`define X_LOW_INDEX 5'h1A
`define Y_LOW_INDEX 5'h1C
`define Z_LOW_INDEX 5'h1E
`define HIGH_BYTE_BIT 5'h01

`define FLAG_OVERFLOW 3
`define FLAG_HALF 5
`define FLAG_TRANSFER 6
`define FLAGS_RESET 8'h00
`define GPR_RESET 8'h00
`define ADDR_RESET 16'h0000
`define POINTER_STEP 16'h0001

`endif

// File: src/flag_xfer_exec.v
// Execution unit for single-flag and data-transfer instructions
`timescale 1ns/100ps
`default_nettype none
`include "flag_xfer_consts.vh"

module flag_xfer_exec #(
  parameter REG_COUNT = 32,
  parameter ADDR_WIDTH = 16
) (
  input wire sys_clk,
  input wire rst,
  input wire instr_valid,
  output wire instr_ready,
  input wire [4:0] instr_op,
  input wire [4:0] instr_rd,
  input wire [4:0] instr_rr,
  input wire [7:0] instr_k,
  input wire [5:0] instr_q,
  input wire [1:0] instr_ptr,
  input wire [1:0] instr_mode,
  input wire [15:0] instr_addr,
  output reg done,
  output reg illegal_op,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_we,
  output reg mem_re,
  input wire [7:0] mem_rdata,
  output reg [7:0] status_flags_register,
  input wire [4:0] dbg_sel,
  output reg [7:0] dbg_data,
  output wire [15:0] x_pointer,
  output wire [15:0] y_pointer,
  output wire [15:0] z_pointer
);

  localparam S_IDLE = 2'h0;
  localparam S_ACCESS = 2'h1;
  localparam S_CAPTURE = 2'h2;

  reg [7:0] gpr [0:REG_COUNT-1];
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [4:0] dest_reg;

  reg [4:0] ptr_low;
  reg [4:0] ptr_high;
  reg [15:0] ptr_value;
  reg [15:0] eff_addr;
  reg [15:0] ptr_new;
  reg ptr_update;
  reg is_read;
  reg is_write;
  reg is_single;
  reg is_legal;
  reg [7:0] flags_next;
  reg done_next;
  reg illegal_next;
  reg [15:0] mem_addr_next;
  reg [7:0] mem_wdata_next;
  reg mem_we_next;
  reg mem_re_next;
  reg [4:0] dest_next;
  reg wb_en;
  reg [7:0] wb_data;

  wire accept;
  integer i;

  assign instr_ready = (state_reg == S_IDLE);
  assign accept = instr_valid && instr_ready;

  assign x_pointer = {gpr[`X_LOW_INDEX | `HIGH_BYTE_BIT], gpr[`X_LOW_INDEX]};
  assign y_pointer = {gpr[`Y_LOW_INDEX | `HIGH_BYTE_BIT], gpr[`Y_LOW_INDEX]};
  assign z_pointer = {gpr[`Z_LOW_INDEX | `HIGH_BYTE_BIT], gpr[`Z_LOW_INDEX]};

  // Pointer selection and address forming
  always @* begin
    case (instr_ptr)
      `PTR_Y: begin
        ptr_low = `Y_LOW_INDEX;
      end
      `PTR_Z: begin
        ptr_low = `Z_LOW_INDEX;
      end
      default: begin
        ptr_low = `X_LOW_INDEX;
      end
    endcase
    ptr_high = ptr_low | `HIGH_BYTE_BIT;
    ptr_value = {gpr[ptr_high], gpr[ptr_low]};
    eff_addr = ptr_value;
    ptr_new = ptr_value;
    ptr_update = 1'b0;
    is_read = 1'b0;
    is_write = 1'b0;
    is_single = 1'b0;
    is_legal = 1'b1;
    case (instr_op)
      `OP_RAISE_OVERFLOW, `OP_CLEAR_OVERFLOW, `OP_RAISE_TRANSFER, `OP_CLEAR_TRANSFER,
      `OP_RAISE_HALF, `OP_CLEAR_HALF, `OP_COPY_REGISTER, `OP_COPY_PAIR,
      `OP_LOAD_CONSTANT: begin
        is_single = 1'b1;
      end
      `OP_READ_POINTER, `OP_WRITE_POINTER: begin
        is_read = (instr_op == `OP_READ_POINTER);
        is_write = (instr_op == `OP_WRITE_POINTER);
        is_legal = (instr_ptr == `PTR_X) || (instr_ptr == `PTR_Y) || (instr_ptr == `PTR_Z);
        case (instr_mode)
          `MODE_PLAIN: begin
            eff_addr = ptr_value;
          end
          `MODE_POST_INC: begin
            eff_addr = ptr_value;
            ptr_new = ptr_value + `POINTER_STEP;
            ptr_update = 1'b1;
          end
          `MODE_PRE_DEC: begin
            eff_addr = ptr_value - `POINTER_STEP;
            ptr_new = ptr_value - `POINTER_STEP;
            ptr_update = 1'b1;
          end
          default: begin
            is_legal = 1'b0;
          end
        endcase
      end
      `OP_READ_OFFSET, `OP_WRITE_OFFSET: begin
        is_read = (instr_op == `OP_READ_OFFSET);
        is_write = (instr_op == `OP_WRITE_OFFSET);
        is_legal = (instr_ptr == `PTR_Y) || (instr_ptr == `PTR_Z);
        eff_addr = ptr_value + {10'h000, instr_q};
      end
      `OP_READ_DIRECT, `OP_WRITE_DIRECT: begin
        is_read = (instr_op == `OP_READ_DIRECT);
        is_write = (instr_op == `OP_WRITE_DIRECT);
        eff_addr = instr_addr;
      end
      default: begin
        is_legal = 1'b0;
      end
    endcase
    if (!is_legal) begin
      is_read = 1'b0;
      is_write = 1'b0;
      is_single = 1'b0;
      ptr_update = 1'b0;
    end
  end

  // Sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (accept && (is_read || is_write)) begin
          state_next = S_ACCESS;
        end
      end
      S_ACCESS: begin
        if (mem_re) begin
          state_next = S_CAPTURE;
        end else begin
          state_next = S_IDLE;
        end
      end
      S_CAPTURE: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Memory request next values
  always @* begin
    mem_addr_next = mem_addr;
    mem_wdata_next = mem_wdata;
    mem_we_next = 1'b0;
    mem_re_next = 1'b0;
    dest_next = dest_reg;
    if (accept && (is_read || is_write)) begin
      mem_addr_next = eff_addr;
      mem_wdata_next = gpr[instr_rr];
      mem_we_next = is_write;
      mem_re_next = is_read;
      dest_next = instr_rd;
    end
  end

  // Memory request strobes and address
  always @(posedge sys_clk) begin
    if (rst) begin
      mem_addr <= `ADDR_RESET;
      mem_wdata <= `GPR_RESET;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      dest_reg <= 5'h00;
    end else begin
      mem_addr <= mem_addr_next;
      mem_wdata <= mem_wdata_next;
      mem_we <= mem_we_next;
      mem_re <= mem_re_next;
      dest_reg <= dest_next;
    end
  end

  // Single-cycle register write port
  always @* begin
    wb_en = 1'b0;
    wb_data = instr_k;
    if (accept) begin
      case (instr_op)
        `OP_COPY_REGISTER: begin
          wb_en = 1'b1;
          wb_data = gpr[instr_rr];
        end
        `OP_LOAD_CONSTANT: begin
          wb_en = 1'b1;
          wb_data = instr_k;
        end
        default: begin
          wb_en = 1'b0;
        end
      endcase
    end
  end

  // Register file
  always @(posedge sys_clk) begin
    if (rst) begin
      for (i = 0; i < REG_COUNT; i = i + 1) begin
        gpr[i] <= `GPR_RESET;
      end
    end else if (state_reg == S_CAPTURE) begin
      gpr[dest_reg] <= mem_rdata;
    end else if (accept) begin
      if (ptr_update) begin
        gpr[ptr_low] <= ptr_new[7:0];
        gpr[ptr_high] <= ptr_new[15:8];
      end
      if (wb_en) begin
        gpr[instr_rd] <= wb_data;
      end
      case (instr_op)
        `OP_COPY_PAIR: begin
          gpr[{instr_rd[4:1], 1'b0}] <= gpr[{instr_rr[4:1], 1'b0}];
          gpr[{instr_rd[4:1], 1'b1}] <= gpr[{instr_rr[4:1], 1'b1}];
        end
        default: begin
        end
      endcase
    end
  end

  // Status flag next value
  always @* begin
    flags_next = status_flags_register;
    if (accept) begin
      case (instr_op)
        `OP_RAISE_OVERFLOW: begin
          flags_next[`FLAG_OVERFLOW] = 1'b1;
        end
        `OP_CLEAR_OVERFLOW: begin
          flags_next[`FLAG_OVERFLOW] = 1'b0;
        end
        `OP_RAISE_TRANSFER: begin
          flags_next[`FLAG_TRANSFER] = 1'b1;
        end
        `OP_CLEAR_TRANSFER: begin
          flags_next[`FLAG_TRANSFER] = 1'b0;
        end
        `OP_RAISE_HALF: begin
          flags_next[`FLAG_HALF] = 1'b1;
        end
        `OP_CLEAR_HALF: begin
          flags_next[`FLAG_HALF] = 1'b0;
        end
        default: begin
          flags_next = status_flags_register;
        end
      endcase
    end
  end

  // Status flags
  always @(posedge sys_clk) begin
    if (rst) begin
      status_flags_register <= `FLAGS_RESET;
    end else begin
      status_flags_register <= flags_next;
    end
  end

  // Completion and error pulse next values
  always @* begin
    done_next = 1'b0;
    illegal_next = 1'b0;
    if (accept && is_single) begin
      done_next = 1'b1;
    end
    if (state_reg == S_CAPTURE) begin
      done_next = 1'b1;
    end
    if ((state_reg == S_ACCESS) && mem_we) begin
      done_next = 1'b1;
    end
    if (accept && !is_legal && (instr_op != `OP_NOP)) begin
      illegal_next = 1'b1;
    end
  end

  // Completion and error pulses
  always @(posedge sys_clk) begin
    if (rst) begin
      done <= 1'b0;
      illegal_op <= 1'b0;
    end else begin
      done <= done_next;
      illegal_op <= illegal_next;
    end
  end

  // Register observation port
  always @(posedge sys_clk) begin
    if (rst) begin
      dbg_data <= `GPR_RESET;
    end else begin
      dbg_data <= gpr[dbg_sel];
    end
  end

endmodule
`default_nettype wire

// File: verification/data_mem_model.sv
// Synchronous data memory behind the execution unit
`timescale 1ns/100ps
`default_nettype none
module data_mem_model (
  input wire sys_clk,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire mem_we,
  input wire mem_re,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
  end
  // Data valid one cycle after a read strobe, toggling otherwise
  always @(posedge sys_clk) begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
    mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
  end
endmodule
`default_nettype wire

// File: verification/flag_xfer_exec_sva.sv
// Port checker for the execution unit
`timescale 1ns/100ps
`default_nettype none
module flag_xfer_exec_chk (
  input wire sys_clk,
  input wire rst,
  input wire instr_valid,
  input wire instr_ready,
  input wire [4:0] instr_op,
  input wire [1:0] instr_ptr,
  input wire [1:0] instr_mode,
  input wire done,
  input wire illegal_op,
  input wire mem_re,
  input wire mem_we,
  input wire [15:0] mem_addr,
  input wire [7:0] status_flags_register,
  input wire [15:0] x_pointer,
  input wire [15:0] y_pointer
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire take = instr_valid && instr_ready;
  wire [7:0] f = status_flags_register;
  a_raise_overflow: assert property (take && instr_op == 5'h01 |=> f[3] && done)
    else $error("overflow raise missed");
  a_clear_overflow: assert property (take && instr_op == 5'h02 |=> !f[3] && done)
    else $error("overflow clear missed");
  a_transfer_bit: assert property (take && (instr_op == 5'h03 || instr_op == 5'h04)
    |=> f[6] == $past(instr_op[0])) else $error("transfer bit wrong");
  a_half_carry: assert property (take && (instr_op == 5'h05 || instr_op == 5'h06)
    |=> f[5] == $past(instr_op[0])) else $error("half carry wrong");
  a_single_flag_only: assert property (take && instr_op >= 5'h01 && instr_op <= 5'h06
    |=> done && f[7] == $past(f[7]) && f[4] == $past(f[4]) && f[2:0] == $past(f[2:0]))
    else $error("other flag disturbed");
  a_copy_flags_kept: assert property (take && instr_op >= 5'h07 && instr_op <= 5'h09
    |=> done && $stable(f)) else $error("copy touched flags");
  a_postinc_x_read: assert property (take && instr_op == 5'h0a && instr_ptr == 2'h0
    && instr_mode == 2'h1 |=> mem_re && mem_addr == $past(x_pointer)
    && x_pointer == $past(x_pointer) + 16'h0001) else $error("post-increment X wrong");
  a_predec_y_write: assert property (take && instr_op == 5'h0d && instr_ptr == 2'h1
    && instr_mode == 2'h2 |=> mem_we && mem_addr == $past(y_pointer) - 16'h0001
    && y_pointer == mem_addr) else $error("pre-decrement Y wrong");
  a_read_latency: assert property (mem_re |-> !instr_ready [*2] ##1 done)
    else $error("read completion wrong");
  a_write_latency: assert property (mem_we |-> !instr_ready ##1 done)
    else $error("write completion wrong");
  a_named_flag_only: assert property (take && instr_op >= 5'h01 && instr_op <= 5'h06
    |=> (f[3] == $past(f[3]) || $past(instr_op) <= 5'h02)
    && (f[6] == $past(f[6]) || $past(instr_op) == 5'h03 || $past(instr_op) == 5'h04)
    && (f[5] == $past(f[5]) || $past(instr_op) >= 5'h05)) else $error("unnamed flag changed");
  a_illegal_no_effect: assert property (take && instr_op == 5'h0a && instr_ptr == 2'h3
    |=> illegal_op && !done && !mem_re && $stable(f) && $stable(x_pointer))
    else $error("illegal pointer had effect");
  c_read: cover property (take && instr_op == 5'h0a);
  c_write: cover property (mem_we);
  c_pair: cover property (take && instr_op == 5'h08);
endmodule
bind flag_xfer_exec flag_xfer_exec_chk i_chk (
  .sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
  .instr_op(instr_op), .instr_ptr(instr_ptr), .instr_mode(instr_mode), .done(done),
  .illegal_op(illegal_op), .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr),
  .status_flags_register(status_flags_register), .x_pointer(x_pointer),
  .y_pointer(y_pointer)
);
`default_nettype wire

// File: verification/tb_flag_and_data_transfer_exec.sv
// Self-checking bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module tb_flag_and_data_transfer_exec;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [4:0] instr_op = 5'h00, instr_rd = 5'h00, instr_rr = 5'h00, dbg_sel = 5'h00;
  logic [7:0] instr_k = 8'h00;
  logic [5:0] instr_q = 6'h00;
  logic [1:0] instr_ptr = 2'h0, instr_mode = 2'h0;
  logic [15:0] instr_addr = 16'h0000;
  wire instr_ready, done, illegal_op, mem_we, mem_re;
  wire [7:0] mem_wdata, mem_rdata, status_flags_register, dbg_data;
  wire [15:0] mem_addr, x_pointer, y_pointer, z_pointer;
  integer failures = 0, compares = 0, seed = 32'h3db9_47d8, i, p, m, w;
  logic [15:0] b, ea, ep;
  logic [7:0] ef, d;
  always #2.5 sys_clk = ~sys_clk;
  flag_xfer_exec i_dut (
    .sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_op(instr_op), .instr_rd(instr_rd), .instr_rr(instr_rr), .instr_k(instr_k),
    .instr_q(instr_q), .instr_ptr(instr_ptr), .instr_mode(instr_mode),
    .instr_addr(instr_addr), .done(done), .illegal_op(illegal_op), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
    .status_flags_register(status_flags_register), .dbg_sel(dbg_sel), .dbg_data(dbg_data),
    .x_pointer(x_pointer), .y_pointer(y_pointer), .z_pointer(z_pointer)
  );
  data_mem_model i_mem (
    .sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata)
  );
  task check(input [15:0] g, input [15:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("ERROR %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task issue(input [4:0] op, rd, rr, input [7:0] k, input [1:0] pt, md, input [15:0] a);
    integer n;
    begin
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      {instr_op, instr_rd, instr_rr, instr_k, instr_q} <= {op, rd, rr, k, k[5:0]};
      {instr_ptr, instr_mode, instr_addr} <= {pt, md, a};
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      #1;
      for (n = 0; n < 8 && done !== 1'b1 && illegal_op !== 1'b1; n = n + 1) begin
        @(posedge sys_clk);
        #1;
      end
      if (n == 8)
        check(16'h0000, 16'h0001);
    end
  endtask
  task chk_reg(input [4:0] r, input [7:0] e);
    begin
      @(posedge sys_clk);
      dbg_sel <= r;
      repeat (2) @(posedge sys_clk);
      #1;
      check(dbg_data, e);
    end
  endtask
  task set_ptr(input [1:0] pt, input [15:0] v);
    begin
      issue(5'h09, 5'h1a + {pt, 1'b0}, 5'h00, v[7:0], 2'h0, 2'h0, 16'h0000);
      issue(5'h09, 5'h1b + {pt, 1'b0}, 5'h00, v[15:8], 2'h0, 2'h0, 16'h0000);
    end
  endtask
  function [15:0] pv(input [1:0] pt);
    pv = pt == 2'h0 ? x_pointer : pt == 2'h1 ? y_pointer : z_pointer;
  endfunction
  function [7:0] pat(input [15:0] a);
    pat = a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  function [7:0] fl(input [7:0] f, input [4:0] op);
    begin
      fl = f;
      fl[op < 3 ? 3 : op < 5 ? 6 : 5] = op[0];
    end
  endfunction
  task print_verdict;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #50000;
    failures = failures + 1;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    ef = 8'h00;
    for (i = 0; i < 24; i = i + 1) begin
      p = 1 + {$random(seed)} % 6;
      issue(p[4:0], 5'h00, 5'h00, 8'h00, 2'h0, 2'h0, 16'h0000);
      ef = fl(ef, p[4:0]);
      check(status_flags_register, ef);
    end
    $display("flag test done");
    d = $random(seed);
    issue(5'h09, 5'h04, 5'h00, d, 2'h0, 2'h0, 16'h0000);
    issue(5'h09, 5'h05, 5'h00, ~d, 2'h0, 2'h0, 16'h0000);
    issue(5'h07, 5'h06, 5'h04, 8'h00, 2'h0, 2'h0, 16'h0000);
    issue(5'h08, 5'h08, 5'h04, 8'h00, 2'h0, 2'h0, 16'h0000);
    chk_reg(5'h04, d);
    chk_reg(5'h06, d);
    chk_reg(5'h08, d);
    chk_reg(5'h09, ~d);
    check(status_flags_register, ef);
    $display("copy test done");
    for (w = 0; w < 2; w = w + 1)
      for (p = 0; p < 3; p = p + 1)
        for (m = 0; m < 4; m = m + 1) begin
          b = p == 0 ? (w ? 16'h0000 : 16'h00ff) : p == 1 && !w ? 16'h0100 : $random(seed);
          d = $random(seed);
          set_ptr(p[1:0], b);
          issue(5'h09, 5'h02, 5'h00, d, 2'h0, 2'h0, 16'h0000);
          issue((m == 3 ? (p ? 5'h0b : 5'h0c) : 5'h0a) + 5'h03 * w[4:0], 5'h01, 5'h02, d,
                p[1:0], m % 3, b);
          ea = m == 2 ? b - 1 : m == 3 && p > 0 ? b + d[5:0] : b;
          ep = m == 1 ? b + 1 : m == 2 ? b - 1 : b;
          check(pv(p[1:0]), ep);
          if (w)
            issue(5'h0c, 5'h01, 5'h00, 8'h00, 2'h0, 2'h0, ea);
          chk_reg(5'h01, w ? d : pat(ea));
        end
    issue(5'h0a, 5'h01, 5'h00, 8'h00, 2'h3, 2'h0, 16'h0000);
    check({done, illegal_op}, 16'h0001);
    issue(5'h0a, 5'h01, 5'h00, 8'h00, 2'h0, 2'h3, 16'h0000);
    check({done, illegal_op}, 16'h0001);
    issue(5'h0b, 5'h01, 5'h00, 8'h00, 2'h0, 2'h0, 16'h0000);
    check({done, illegal_op}, 16'h0001);
    check(status_flags_register, ef);
    $display("memory test done");
    print_verdict;
  end
endmodule
`default_nettype wire
